// [isx_consts.svh]
// Constants for the increment-skip and exclusive-OR execute block
`ifndef ISX_CONSTS_SVH
`define ISX_CONSTS_SVH
`define ISX_OPC_INC_SKIP_NZ 6'h12
`define ISX_OPC_XOR_WF 6'h06
`define ISX_INDEXED_LIMIT 8'h5F
`define ISX_ACCESS_SPLIT 8'h60
`define ISX_ACCESS_HIGH_BANK 4'hF
`define ISX_W_RESET 8'h00
`define ISX_STATUS_N_BIT 4
`define ISX_STATUS_Z_BIT 2
`endif

// [isx_pkg.sv]
// Types for the increment-skip and exclusive-OR execute block
package isx_pkg;
    typedef enum logic [1:0] {ISX_Q1, ISX_Q2, ISX_Q3, ISX_Q4} isx_phase_t;
    typedef enum logic [1:0] {ISX_OP_NONE, ISX_OP_INC, ISX_OP_XOR} isx_op_t;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] data;
        logic we;
    } isx_mem_t;
endpackage : isx_pkg

// [isx_exec.sv]
// Execute unit for increment-skip-if-nonzero and exclusive-OR working with file
`include "isx_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module isx_exec
    import isx_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 12
)
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic [15:0] INSTR,
    input wire logic INSTR_VALID,
    input wire logic EXT_SET_EN,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic [11:0] INDEX_BASE,
    input wire logic [7:0] STATUS_IN,
    input wire logic [7:0] MEM_RDATA,
    output logic [11:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WE,
    output logic [7:0] W_OUT,
    output logic [7:0] STATUS_OUT,
    output logic STATUS_WE,
    output logic FLUSH,
    output logic CYCLE_DONE,
    output logic HANDLED
);
    // Registered state of the execute pipeline, then the combinational decode and address signals
    isx_phase_t phase_q;
    isx_op_t op_q;
    isx_mem_t mem_q;
    logic dir_q;
    logic [7:0] w_q;
    logic [7:0] result_q;
    logic [7:0] status_q;
    logic status_we_q;
    logic flush_q;
    logic done_q;
    logic skip_pend_q;
    isx_op_t op_d;
    logic [11:0] addr_d;
    logic [7:0] f_addr;

    assign f_addr = INSTR[7:0];

    // The datapath is written for byte data and a 12-bit data space
    // Any other size would silently truncate addresses, so it is refused
    if (DATA_W != 8 || ADDR_W != 12)
    begin : g_size_check
        $error("isx_exec supports only DATA_W 8 and ADDR_W 12");
    end

    // Decode; a skip-pending cycle is forced to a no-op
    // HANDLED follows this decode combinationally and may glitch while INSTR settles
    // Consumers should only look at it on the clock edge
    always_comb
    begin
        op_d = ISX_OP_NONE;
        if (INSTR_VALID && !skip_pend_q)
        begin
            if (INSTR[15:10] == `ISX_OPC_INC_SKIP_NZ)
                op_d = ISX_OP_INC;
            else if (INSTR[15:10] == `ISX_OPC_XOR_WF)
                op_d = ISX_OP_XOR;
        end
    end

    // Effective address generation
    // Bank bit set: bank select register supplies the upper nibble
    // Bank bit clear: access bank, with the indexed window below 60h when
    // the extended set is on; the indexed sum wraps inside the data space
    always_comb
    begin
        if (INSTR[8])
            addr_d = {BANK_SELECT_REGISTER, f_addr};
        else if (EXT_SET_EN && f_addr <= `ISX_INDEXED_LIMIT)
            addr_d = INDEX_BASE + {4'h0, f_addr};
        else if (f_addr < `ISX_ACCESS_SPLIT)
            addr_d = {4'h0, f_addr};
        else
            addr_d = {`ISX_ACCESS_HIGH_BANK, f_addr};
    end

    // Four enabled edges make one instruction cycle
    // CLK_EN low freezes the count, so a stalled core resumes in the same phase
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            phase_q <= ISX_Q1;
        else if (CLK_EN)
            phase_q <= isx_phase_t'(phase_q + 2'h1);
    end

    // Q1 decode, Q2 read, Q3 process, Q4 write
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            op_q <= ISX_OP_NONE;
            dir_q <= 1'b0;
            mem_q <= '0;
            result_q <= 8'h00;
        end
        else if (CLK_EN)
        begin
            mem_q.we <= 1'b0;
            case (phase_q)
                ISX_Q1:
                begin
                    op_q <= op_d;
                    dir_q <= INSTR[9];
                    mem_q.addr <= addr_d;
                end
                ISX_Q2:
                begin
                    result_q <= MEM_RDATA;
                end
                ISX_Q3:
                begin
                    if (op_q == ISX_OP_INC)
                        result_q <= result_q + 8'h01;
                    else if (op_q == ISX_OP_XOR)
                        result_q <= result_q ^ w_q;
                end
                ISX_Q4:
                begin
                    mem_q.data <= result_q;
                    mem_q.we <= (op_q != ISX_OP_NONE) && dir_q;
                end
                default:
                begin
                    op_q <= ISX_OP_NONE;
                end
            endcase
        end
    end

    // W is written at Q4, so the next instruction already reads the new value
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            w_q <= `ISX_W_RESET;
        else if (CLK_EN && phase_q == ISX_Q4 && op_q != ISX_OP_NONE && !dir_q)
            w_q <= result_q;
    end

    // Flags: only N and Z after XOR; increment leaves status untouched
    // STATUS_IN is taken at Q4 so bits owned by other units are passed through
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            status_q <= 8'h00;
            status_we_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            status_we_q <= 1'b0;
            if (phase_q == ISX_Q4 && op_q == ISX_OP_XOR)
            begin
                status_q <= STATUS_IN;
                status_q[`ISX_STATUS_N_BIT] <= result_q[7];
                status_q[`ISX_STATUS_Z_BIT] <= (result_q == 8'h00);
                status_we_q <= 1'b1;
            end
        end
    end

    // Skip: nonzero increment flushes the prefetched word; the next slot runs as a no-op
    // Limitation: a two-word follow-on is not tracked, only one slot is dropped
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flush_q <= 1'b0;
            skip_pend_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            flush_q <= 1'b0;
            done_q <= (phase_q == ISX_Q4);
            if (phase_q == ISX_Q4 && op_q == ISX_OP_INC && result_q != 8'h00)
            begin
                flush_q <= 1'b1;
                skip_pend_q <= 1'b1;
            end
            else if (phase_q == ISX_Q4)
                skip_pend_q <= 1'b0;
        end
    end


    // Data outputs come straight from flip-flops; only HANDLED is combinational
    assign MEM_ADDR = mem_q.addr;
    assign MEM_WDATA = mem_q.data;
    assign MEM_WE = mem_q.we;
    assign W_OUT = w_q;
    assign STATUS_OUT = status_q;
    assign STATUS_WE = status_we_q;
    assign FLUSH = flush_q;
    assign CYCLE_DONE = done_q;
    assign HANDLED = (op_d != ISX_OP_NONE);
endmodule : isx_exec
`default_nettype wire

// [isx_exec_assertions.sv]
// Concurrent checks on the increment-skip and exclusive-OR execute unit
`include "isx_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module isx_chk
    import isx_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [15:0] INSTR,
    input wire logic [7:0] MEM_WDATA,
    input wire logic MEM_WE,
    input wire logic [7:0] W_OUT,
    input wire logic [7:0] STATUS_OUT,
    input wire logic STATUS_WE,
    input wire logic FLUSH,
    input wire logic CYCLE_DONE,
    input wire logic HANDLED
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] res;
    // Result lands in memory data or in W, by direction
    assign res = MEM_WE ? MEM_WDATA : W_OUT;
    sequence quiet_3;
        !CYCLE_DONE [*3];
    endsequence
    we_pulse_a: assert property (MEM_WE |=> !MEM_WE)
        else $error("write pulse too long");
    w_hold_a: assert property (MEM_WE |-> $stable(W_OUT))
        else $error("W changed on file write");
    skip_nz_a: assert property (MEM_WE && !STATUS_WE |-> FLUSH == (MEM_WDATA != 8'h00))
        else $error("skip not tied to nonzero sum");
    done_gap_a: assert property (CYCLE_DONE |=> quiet_3)
        else $error("instruction cycle shorter than four phases");
    flag_val_a: assert property (STATUS_WE |-> STATUS_OUT[4] == res[7] &&
        STATUS_OUT[2] == (res == 8'h00)) else $error("wrong negative or zero flag");
    no_flag_a: assert property (FLUSH |-> !STATUS_WE)
        else $error("increment touched status");
    decode_a: assert property (INSTR[15:10] != `ISX_OPC_XOR_WF &&
        INSTR[15:10] != `ISX_OPC_INC_SKIP_NZ |-> !HANDLED) else $error("foreign opcode taken");
endmodule : isx_chk
bind isx_exec isx_chk u_chk (.*);
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the increment-skip and exclusive-OR execute unit
`timescale 1ns/100ps
`default_nettype none
module testbench
    import isx_pkg::*;
;
    logic REF_CLK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, INSTR_VALID = 1'b1, EXT_SET_EN = 1'b0;
    logic [15:0] INSTR = 16'h0000;
    logic [3:0] BANK_SELECT_REGISTER = 4'h3;
    logic [11:0] INDEX_BASE = 12'h120, MEM_ADDR;
    logic [7:0] STATUS_IN = 8'hFF, MEM_RDATA = 8'h00, MEM_WDATA, W_OUT, STATUS_OUT;
    logic MEM_WE, STATUS_WE, FLUSH, CYCLE_DONE, HANDLED;
    int n_errors = 0, checks_done = 0;
    isx_exec DUT (.*);
    initial forever #2.5 REF_CLK = ~REF_CLK;
    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok)
        begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask : chk
    // Four enabled edges per instruction; outputs read 1 ns after the write phase
    task automatic op(input logic [15:0] i, input logic [7:0] rd);
        INSTR <= i;
        MEM_RDATA <= rd;
        repeat (4) @(posedge REF_CLK);
        #1;
    endtask : op
    task automatic t_xor;
        op(16'h1834, 8'hB5);
        chk(W_OUT === 8'hB5 && MEM_WE === 1'b0, "xor to W");
        chk(STATUS_WE === 1'b1 && STATUS_OUT === 8'hFB, "xor flags");
        op(16'h1A34, 8'hAF);
        chk(MEM_WE === 1'b1 && MEM_WDATA === 8'h1A && W_OUT === 8'hB5, "xor to f");
        chk(STATUS_OUT === 8'hEB, "xor flags");
        $display("t_xor end");
    endtask : t_xor
    task automatic t_wrap;
        op(16'h4834, 8'hFF);
        chk(W_OUT === 8'h00 && FLUSH === 1'b0 && MEM_ADDR === 12'h034, "zero sum");
        chk(STATUS_WE === 1'b0 && MEM_WE === 1'b0, "inc to W");
        op(16'h1834, 8'h00);
        chk(STATUS_WE === 1'b1 && STATUS_OUT === 8'hEF, "no skip");
        $display("t_wrap end");
    endtask : t_wrap
    task automatic t_skip;
        op(16'h4B34, 8'h7F);
        chk(MEM_WE === 1'b1 && MEM_WDATA === 8'h80 && FLUSH === 1'b1, "skip");
        chk(MEM_ADDR === 12'h334 && STATUS_WE === 1'b0, "bank");
        op(16'h1B34, 8'h55);
        chk(MEM_WE === 1'b0 && STATUS_WE === 1'b0, "flushed");
        $display("t_skip end");
    endtask : t_skip
    task automatic t_index;
        EXT_SET_EN <= 1'b1;
        op(16'h4A5F, 8'h10);
        chk(MEM_ADDR === 12'h17F && MEM_WDATA === 8'h11, "indexed");
        op(16'h0000, 8'h00);
        op(16'h4A60, 8'h20);
        chk(MEM_ADDR === 12'hF60 && MEM_WDATA === 8'h21, "access");
        $display("t_index end");
    endtask : t_index
    task automatic t_misc;
        op(16'h0000, 8'h00);
        INSTR_VALID <= 1'b0;
        op(16'h1A34, 8'h0F);
        chk(MEM_WE === 1'b0 && STATUS_WE === 1'b0 && HANDLED === 1'b0, "invalid");
        chk(CYCLE_DONE === 1'b1, "cycle done");
        INSTR_VALID <= 1'b1;
        INSTR <= 16'h1834;
        MEM_RDATA <= 8'h0F;
        @(posedge REF_CLK);
        CLK_EN <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        chk(HANDLED === 1'b1 && W_OUT === 8'h00 && CYCLE_DONE === 1'b0, "frozen");
        CLK_EN <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        #1;
        chk(W_OUT === 8'h0F && STATUS_OUT === 8'hEB, "resume");
        $display("t_misc end");
    endtask : t_misc
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial
    begin
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        t_xor();
        t_wrap();
        t_skip();
        t_index();
        t_misc();
        results();
    end
endmodule : testbench
`default_nettype wire
